// *** core/ea_gen_defines.svh ***
// constants for the effective address generator
`ifndef EA_GEN_DEFINES_SVH
`define EA_GEN_DEFINES_SVH
`define EA_ADDR_W 32
`define EA_WORD_W 16
`define EA_REG_IDX_W 4
`define EA_NIL_REG 4'h0
`define EA_OFFSET_W 16
`endif

// *** core/ea_gen_pkg.sv ***
// types for the effective address generator
package ea_gen_pkg;
  typedef enum logic [2:0] {
    CONSTANT_LOCATION_MODE = 3'h0,
    CONSTANT_PLUS_SLOT_MODE = 3'h1,
    ANCHOR_PLUS_OFFSET_MODE = 3'h2,
    ANCHOR_PLUS_SLOT_PLUS_OFFSET_MODE = 3'h3,
    PC_PLUS_OFFSET_MODE = 3'h4,
    PC_PLUS_SLOT_PLUS_OFFSET_MODE = 3'h5
  } ea_mode_t;
  typedef enum logic [1:0] {
    SPACE_DATA = 2'h0,
    SPACE_INSTR = 2'h1,
    SPACE_PROGRAM = 2'h2,
    SPACE_IO = 2'h3
  } ea_space_t;
endpackage

// *** core/effective_address_generator.sv ***
// effective address datapath for segmented and linear representations
`timescale 1ns/1ps
`include "ea_gen_defines.svh"
////////////////////////////////////////////////////////////////////////
// Function
// - anchor plus offset: address is base register plus displacement
// - anchor base register zero is invalid for anchor plus offset
// - both anchor modes access data memory space
// - anchor plus slot plus offset: base plus index plus displacement
// - anchor plus slot plus offset base must not be register zero
// - indexed modes: index register zero, word or long, is invalid
// - word index is sign extended to 32 bits before adding
// - pc plus offset: address is pc plus displacement
// - pc used is address of word after displacement, supplied by decoder
// - pc plus offset operands use instruction memory space
// - pc plus slot plus offset: pc plus index plus displacement
// - pc plus slot plus offset operands use program memory space
// - extension words are fetched by decoder before calculation starts
// - only six extension word group modes in segmented or linear
// - constant plus slot: carried address plus valid index
// - constant location: carried address, data or io by opcode
module effective_address_generator #(
  parameter int ADDR_W = `EA_ADDR_W,
  parameter int OFFSET_W = `EA_OFFSET_W
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic reqValid,
  input wire ea_gen_pkg::ea_mode_t reqMode,
  input wire logic segmented,
  input wire logic ioAccess,
  input wire logic [ADDR_W-1:0] extValue,
  input wire logic [ADDR_W-1:0] baseValue,
  input wire logic [`EA_REG_IDX_W-1:0] baseSel,
  input wire logic [ADDR_W-1:0] indexValue,
  input wire logic [`EA_REG_IDX_W-1:0] indexSel,
  input wire logic indexIsWord,
  input wire logic [ADDR_W-1:0] pcNext,
  output logic eaValid,
  output logic [ADDR_W-1:0] eaAddr,
  output ea_gen_pkg::ea_space_t eaSpace,
  output logic eaFault
);
  ////////////////////////////////////////////////////////////////////////
  logic [ADDR_W-1:0] indexExt;
  logic [ADDR_W-1:0] next_sum;
  logic [ADDR_W-1:0] next_addr;
  ea_gen_pkg::ea_space_t next_space;
  logic next_fault;
  logic usesIndex;
  logic usesBase;
  logic [ADDR_W-OFFSET_W-1:0] segField;

  // word index sign extended from 16 bits
  assign indexExt = indexIsWord ?
    {{(ADDR_W-`EA_WORD_W){indexValue[`EA_WORD_W-1]}}, indexValue[`EA_WORD_W-1:0]} :
    indexValue;

  // operands arrive with extension words already fetched
  always_comb
  begin
    next_sum = '0;
    usesIndex = 1'b0;
    usesBase = 1'b0;
    next_fault = 1'b0;
    case (reqMode)
      ea_gen_pkg::CONSTANT_LOCATION_MODE:
      begin
        next_sum = extValue;
      end
      ea_gen_pkg::CONSTANT_PLUS_SLOT_MODE:
      begin
        next_sum = extValue + indexExt;
        usesIndex = 1'b1;
      end
      ea_gen_pkg::ANCHOR_PLUS_OFFSET_MODE:
      begin
        next_sum = baseValue + extValue;
        usesBase = 1'b1;
      end
      ea_gen_pkg::ANCHOR_PLUS_SLOT_PLUS_OFFSET_MODE:
      begin
        next_sum = baseValue + indexExt + extValue;
        usesBase = 1'b1;
        usesIndex = 1'b1;
      end
      ea_gen_pkg::PC_PLUS_OFFSET_MODE:
      begin
        // pcNext already points past the displacement word
        next_sum = pcNext + extValue;
      end
      ea_gen_pkg::PC_PLUS_SLOT_PLUS_OFFSET_MODE:
      begin
        next_sum = pcNext + indexExt + extValue;
        usesIndex = 1'b1;
      end
      default:
      begin
        next_fault = 1'b1;
      end
    endcase
    if (usesBase && baseSel == `EA_NIL_REG)
    begin
      next_fault = 1'b1;
    end
    if (usesIndex && indexSel == `EA_NIL_REG)
    begin
      next_fault = 1'b1;
    end
  end

  // memory space depends on mode, and on ioAccess for constant location; faulting requests still carry one
  always_comb
  begin
    next_space = ea_gen_pkg::SPACE_DATA;
    case (reqMode)
      ea_gen_pkg::CONSTANT_LOCATION_MODE:
      begin
        next_space = ioAccess ? ea_gen_pkg::SPACE_IO : ea_gen_pkg::SPACE_DATA;
      end
      ea_gen_pkg::ANCHOR_PLUS_OFFSET_MODE,
      ea_gen_pkg::ANCHOR_PLUS_SLOT_PLUS_OFFSET_MODE:
      begin
        next_space = ea_gen_pkg::SPACE_DATA;
      end
      ea_gen_pkg::PC_PLUS_OFFSET_MODE:
      begin
        next_space = ea_gen_pkg::SPACE_INSTR;
      end
      ea_gen_pkg::PC_PLUS_SLOT_PLUS_OFFSET_MODE:
      begin
        next_space = ea_gen_pkg::SPACE_PROGRAM;
      end
      default:
      begin
        next_space = ea_gen_pkg::SPACE_DATA;
      end
    endcase
  end

  // segment number comes from whichever operand carries the full address
  always_comb
  begin
    segField = extValue[ADDR_W-1:OFFSET_W];
    case (reqMode)
      ea_gen_pkg::ANCHOR_PLUS_OFFSET_MODE,
      ea_gen_pkg::ANCHOR_PLUS_SLOT_PLUS_OFFSET_MODE:
      begin
        segField = baseValue[ADDR_W-1:OFFSET_W];
      end
      ea_gen_pkg::PC_PLUS_OFFSET_MODE,
      ea_gen_pkg::PC_PLUS_SLOT_PLUS_OFFSET_MODE:
      begin
        segField = pcNext[ADDR_W-1:OFFSET_W];
      end
      default:
      begin
        segField = extValue[ADDR_W-1:OFFSET_W];
      end
    endcase
  end

  // segment field left alone; carry out of the offset is dropped on purpose,
  // so a table that runs past the segment end wraps inside it
  always_comb
  begin
    if (segmented)
    begin
      next_addr = {segField, next_sum[OFFSET_W-1:0]};
    end
    else
    begin
      next_addr = next_sum;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      eaValid <= 1'b0;
    end
    else
    begin
      eaValid <= reqValid;
    end
  end

  // address holds between requests so the consumer may read it late
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      eaAddr <= '0;
    end
    else if (reqValid)
    begin
      eaAddr <= next_addr;
    end
  end

  // space travels with the address it belongs to
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      eaSpace <= ea_gen_pkg::SPACE_DATA;
    end
    else if (reqValid)
    begin
      eaSpace <= next_space;
    end
  end

  // fault is a level per request, not sticky: software sees each verdict
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      eaFault <= 1'b0;
    end
    else if (reqValid)
    begin
      eaFault <= next_fault;
    end
  end
endmodule

// *** verification/ea_src_model.sv ***
// register file model standing in for the decoder side
`timescale 1ns/1ps
module ea_src_model (
  input wire logic [3:0] baseSel,
  input wire logic [3:0] indexSel,
  output logic [31:0] baseValue,
  output logic [31:0] indexValue
);
  logic [31:0] regs [16];
  // fixed spread of values so word indexes hit both signs
  initial foreach (regs[i]) regs[i] = 32'h9E3779B9 * (i + 1);
  assign baseValue = regs[baseSel];
  assign indexValue = regs[indexSel];
endmodule

// *** verification/ea_gen_chk.sv ***
// port checks for the address generator
`timescale 1ns/1ps
module ea_gen_chk (
  input wire logic core_clk, rst_b, reqValid, segmented, ioAccess, indexIsWord,
  input wire ea_gen_pkg::ea_mode_t reqMode,
  input wire logic [31:0] extValue, baseValue, indexValue, pcNext, eaAddr,
  input wire logic [3:0] baseSel, indexSel,
  input wire logic eaValid, eaFault,
  input wire ea_gen_pkg::ea_space_t eaSpace
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic go;
  assign go = reqValid && !segmented && !indexIsWord;
  resp_pulse_a: assert property (reqValid |=> eaValid) else $error("no answer");
  no_stray_a: assert property (!reqValid |=> !eaValid) else $error("stray answer");
  anchor_sum_a: assert property (go && reqMode == 3'h2 |=>
    eaAddr == $past(baseValue) + $past(extValue)) else $error("anchor sum");
  pc_sum_a: assert property (go && reqMode == 3'h4 |=>
    eaAddr == $past(pcNext) + $past(extValue)) else $error("pc sum");
  pc_slot_a: assert property (go && reqMode == 3'h5 |=>
    eaAddr == $past(pcNext) + $past(indexValue) + $past(extValue)) else $error("pc index sum");
  word_idx_a: assert property (reqValid && !segmented && indexIsWord && reqMode == 3'h1 |=>
    eaAddr == $past(extValue) + {{16{$past(indexValue[15])}}, $past(indexValue[15:0])})
    else $error("word index not extended");
  idx_nil_a: assert property (reqValid && reqMode inside {3'h1, 3'h3, 3'h5} && indexSel == 4'h0
    |=> eaFault) else $error("nil index kept");
  io_space_a: assert property (reqValid && reqMode == 3'h0 && ioAccess |=> eaSpace == 2'h3)
    else $error("not io space");
  bad_mode_a: assert property (reqValid && reqMode inside {3'h6, 3'h7} |=> eaFault)
    else $error("illegal mode accepted");
  addr_hold_a: assert property (!reqValid |=> $stable(eaAddr) && $stable(eaSpace))
    else $error("result moved without request");
  data_space_a: assert property (reqValid && reqMode inside {3'h2, 3'h3} |=>
    eaSpace == 2'h0) else $error("not data space");
  instr_space_a: assert property (reqValid && reqMode == 3'h4 |=> eaSpace == 2'h1)
    else $error("not instruction space");
  prog_space_a: assert property (reqValid && reqMode == 3'h5 |=> eaSpace == 2'h2)
    else $error("not program space");
  nil_base_a: assert property (reqValid && reqMode inside {3'h2, 3'h3} && baseSel == 4'h0
    |=> eaFault) else $error("nil base kept");
  seg_keep_a: assert property (reqValid && segmented && reqMode == 3'h2 |=>
    eaAddr[31:16] == $past(baseValue[31:16])) else $error("segment changed");
  cover property (reqValid ##1 reqValid);
  cover property (reqValid && reqMode == 3'h3 && indexIsWord);
  cover property (eaValid && eaFault);
endmodule
bind effective_address_generator ea_gen_chk i_chk (.*);

// *** verification/effective_address_generator_tb.sv ***
// self-checking bench for the address generator
`timescale 1ns/1ps
module effective_address_generator_tb;
  typedef struct packed {logic [31:0] a; ea_gen_pkg::ea_space_t s; logic f;} exp_t;
  logic core_clk = 0, rst_b = 0, reqValid = 0, segmented = 0, ioAccess = 0, indexIsWord = 0;
  ea_gen_pkg::ea_mode_t reqMode = ea_gen_pkg::CONSTANT_LOCATION_MODE;
  logic [31:0] extValue = 0, pcNext = 0, baseValue, indexValue, eaAddr, x, s, src;
  logic [3:0] baseSel = 0, indexSel = 0;
  logic eaValid, eaFault;
  ea_gen_pkg::ea_space_t eaSpace;
  exp_t q[$];
  int err_total = 0, num_checks = 0;
  always #2.5 core_clk = ~core_clk;
  effective_address_generator i_dut (.*);
  ea_src_model i_src (.*);
  task automatic check(input exp_t seen, input exp_t want);
    num_checks++;
    if (seen !== want)
    begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic conclude();
    if (err_total == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h0C9E));
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (400)
    begin
      @(posedge core_clk);
      // mostly back-to-back, nil selects arise one time in sixteen
      reqValid <= ($urandom_range(3) != 0);
      reqMode <= ea_gen_pkg::ea_mode_t'($urandom_range(7));
      {segmented, ioAccess, indexIsWord, baseSel, indexSel} <= 11'($urandom);
      extValue <= $urandom;
      pcNext <= $urandom;
      #1;
      x = indexIsWord ? {{16{indexValue[15]}}, indexValue[15:0]} : indexValue;
      src = reqMode[2] ? pcNext : reqMode[1] ? baseValue : extValue;
      s = (reqMode[2:1] != 2'h0 ? src : 32'h0) + extValue + (reqMode[0] ? x : 32'h0);
      // illegal modes report a zero offset in the carried segment
      if (reqMode[2:1] == 2'h3)
      begin
        s = 32'h0;
        src = extValue;
      end
      if (reqValid)
        q.push_back({segmented ? {src[31:16], s[15:0]} : s,
          ea_gen_pkg::ea_space_t'(reqMode == 5 ? 2'h2 : reqMode == 4 ? 2'h1 :
          (reqMode == 0 && ioAccess) ? 2'h3 : 2'h0),
          (reqMode[0] && indexSel == 4'h0) || (reqMode[2:1] == 2'h1 && baseSel == 4'h0) ||
          (reqMode[2:1] == 2'h3)});
    end
    @(posedge core_clk);
    reqValid <= 1'b0;
    repeat (3) @(posedge core_clk);
    check(exp_t'(q.size()), exp_t'(0));
    conclude();
  end
  always @(negedge core_clk)
    if (eaValid === 1'b1)
      check({eaAddr, eaSpace, eaFault}, q.size() ? q.pop_front() : 'x);
  initial
  begin
    #10000;
    err_total++;
    conclude();
  end
endmodule
